// *** logic/csfp_core.sv ***
// Status flags, program-counter low byte and table-read registers of the core
`timescale 1ns/100ps
module csfp_core (
  // Clock, reset, enable
  input  wire logic                    mclk,
  input  wire logic                    reset,
  input  wire logic                    clkEn,
  // Data-space register access
  input  wire csfp_pkg::csfp_byte_wr_t sfrWr,
  input  wire logic [7:0]              sfrRdAddr,
  output logic [7:0]                   sfrRdData_q,
  // ALU request and result
  input  wire csfp_pkg::csfp_alu_req_t aluReq,
  output logic [7:0]                   aluResult_q,
  // Program counter
  input  wire logic                    pcInc,
  input  wire csfp_pkg::csfp_pc_load_t pcLoad,
  output logic [csfp_pkg::PC_W-1:0]    pc_q,
  output logic                         fetchHold_q,
  // Table read
  input  wire csfp_pkg::csfp_tbl_req_t tblReq,
  output logic [15:0]                  progAddr_q,
  output logic                         progReq_q,
  input  wire logic [csfp_pkg::PROG_W-1:0] progData,
  input  wire logic                    progValid,
  output logic                         tblBusy_q,
  output csfp_pkg::csfp_byte_wr_t      memWr_q,
  // System events and flags
  input  wire logic                    watchdogExpire,
  input  wire logic                    watchdogClear,
  input  wire logic                    halt,
  output logic [7:0]                   status_q
);
  import csfp_pkg::*;

  csfp_state_t state_q;
  csfp_state_t state_d;
  logic [7:0]  tblPtrLo_q;
  logic [7:0]  tblPtrHi_q;
  logic [7:0]  tblHigh_q;
  logic [7:0]  tblDst_q;
  logic [7:0]  status_d;

  // Register decode
  wire         pcLowWr   = sfrWr.en && (sfrWr.addr == SFR_PC_LOW);
  wire         ptrLoWr   = sfrWr.en && (sfrWr.addr == SFR_TPTR_LO);
  wire         ptrHiWr   = sfrWr.en && (sfrWr.addr == SFR_TPTR_HI);
  wire         resHiWr   = sfrWr.en && (sfrWr.addr == SFR_TRES_HI);
  wire         statusWr  = sfrWr.en && (sfrWr.addr == SFR_STATUS);
  wire [7:0]   wrData    = sfrWr.data;
  wire [15:0]  tblPtr    = {tblPtrHi_q, tblPtrLo_q};
  wire [7:0]   progHi    = progData[15:8];
  wire [7:0]   progLo    = progData[7:0];

  // ALU operation classes
  wire         opAdd     = aluReq.valid && (aluReq.op == ALU_ADD || aluReq.op == ALU_ADC);
  wire         opSub     = aluReq.valid && (aluReq.op == ALU_SUB);
  wire         opSbc     = aluReq.valid && (aluReq.op == ALU_SBC);
  wire         opArith   = opAdd || opSub || opSbc;
  wire         opLogic   = aluReq.valid && (aluReq.op == ALU_AND || aluReq.op == ALU_OR
                                            || aluReq.op == ALU_XOR);
  wire         opRrc     = aluReq.valid && (aluReq.op == ALU_RRC);
  wire         opRlc     = aluReq.valid && (aluReq.op == ALU_RLC);

  // Subtraction adds the inverted operand; carry-in is 1 or the old carry
  wire [7:0]   opB       = (opSub || opSbc) ? ~aluReq.b : aluReq.b;
  wire         carryIn   = opSub ? 1'b1
                         : ((aluReq.op == ALU_ADC) || opSbc) ? status_q[FLAG_C] : 1'b0;
  wire [8:0]   sum9      = {1'b0, aluReq.a} + {1'b0, opB} + {8'h00, carryIn};
  wire [4:0]   sumLow    = {1'b0, aluReq.a[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
  wire [7:0]   sum7      = {1'b0, aluReq.a[6:0]} + {1'b0, opB[6:0]} + {7'h00, carryIn};
  wire         carryOut  = sum9[8];
  wire         ovNext    = sum7[7] ^ sum9[8];
  wire [7:0]   logicRes  = (aluReq.op == ALU_AND) ? (aluReq.a & aluReq.b)
                         : (aluReq.op == ALU_OR)  ? (aluReq.a | aluReq.b)
                         : (aluReq.a ^ aluReq.b);
  wire [7:0]   rotRes    = opRrc ? {status_q[FLAG_C], aluReq.a[7:1]}
                                 : {aluReq.a[6:0], status_q[FLAG_C]};
  wire [7:0]   aluRes    = opArith ? sum9[7:0] : opLogic ? logicRes : rotRes;
  wire         zeroNext  = (aluRes == 8'h00);

  // Helper for checking the add carry independently of the shared adder
  wire [8:0]   addCheck  = {1'b0, aluReq.a} + {1'b0, aluReq.b};
  wire [4:0]   addLowChk = {1'b0, aluReq.a[3:0]} + {1'b0, aluReq.b[3:0]};
  // Signed overflow of a plain add: like signs in, other sign out
  wire         addOvChk  = (aluReq.a[7] == aluReq.b[7]) && (addCheck[7] != aluReq.a[7]);

  // Table read may start only from the running state
  wire         tblStart  = tblReq.en && (state_q == ST_RUN) && !pcLowWr;
  wire         tblDone   = (state_q == ST_TBL) && progValid;

  always_comb begin
    status_d = status_q;
    if (opArith) begin
      status_d[FLAG_C]  = carryOut;
      status_d[FLAG_NIB]  = sumLow[4];
      status_d[FLAG_Z]    = zeroNext;
      status_d[FLAG_OVFL] = ovNext;
      status_d[FLAG_SGNX] = ovNext ^ aluRes[7];
    end
    if (opLogic) begin
      status_d[FLAG_Z] = zeroNext;
    end
    if (opRrc) begin
      status_d[FLAG_C] = aluReq.a[0];
    end
    if (opRlc) begin
      status_d[FLAG_C] = aluReq.a[7];
    end
    if (opSub) begin
      status_d[FLAG_CHZ] = zeroNext;
    end
    if (opSbc) begin
      status_d[FLAG_CHZ] = status_q[FLAG_CHZ] && zeroNext;
    end
    // Explicit write wins over ALU updates, but never reaches the system flags
    if (statusWr) begin
      status_d = (wrData & STATUS_SW_MASK) | (status_q & ~STATUS_SW_MASK);
    end
    // Expiry wins over a same-cycle clear so the event is never lost
    if (watchdogExpire) begin
      status_d[FLAG_WDEXP] = 1'b1;
    end else if (watchdogClear || halt) begin
      status_d[FLAG_WDEXP] = 1'b0;
    end
    // Halt wins over a same-cycle watchdog clear
    if (halt) begin
      status_d[FLAG_PWRDN] = 1'b1;
    end else if (watchdogClear) begin
      status_d[FLAG_PWRDN] = 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (pcLowWr) begin
          state_d = ST_DUMMY;
        end else if (tblStart) begin
          state_d = ST_TBL;
        end
      end
      // A further low-byte write still earns its own dummy cycle
      ST_DUMMY: begin
        if (pcLowWr) begin
          state_d = ST_DUMMY;
        end else begin
          state_d = ST_RUN;
        end
      end
      ST_TBL: begin
        if (progValid) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Flags; no save on call or interrupt, software keeps a copy if needed
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_q <= STATUS_RST;
    end else if (clkEn) begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      aluResult_q <= BYTE_RST;
    end else if (clkEn && aluReq.valid && aluReq.op != ALU_NONE) begin
      aluResult_q <= aluRes;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q     <= ST_RUN;
      fetchHold_q <= 1'b0;
      tblBusy_q   <= 1'b0;
    end else if (clkEn) begin
      state_q     <= state_d;
      fetchHold_q <= (state_d == ST_DUMMY);
      tblBusy_q   <= (state_d == ST_TBL);
    end
  end

  // Program counter: low-byte write stays inside the current page
  always_ff @(posedge mclk) begin
    if (reset) begin
      pc_q <= PC_RST;
    end else if (clkEn) begin
      if (pcLowWr) begin
        pc_q <= {pc_q[PC_W-1:8], wrData};
      end else if (pcLoad.en) begin
        pc_q <= pcLoad.target;
      end else if (pcInc && state_q != ST_DUMMY) begin
        pc_q <= pc_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tblPtrLo_q <= BYTE_RST;
      tblPtrHi_q <= BYTE_RST;
    end else if (clkEn) begin
      if (ptrLoWr) begin
        tblPtrLo_q <= wrData;
      end
      if (ptrHiWr) begin
        tblPtrHi_q <= wrData;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      progAddr_q <= 16'h0000;
      progReq_q  <= 1'b0;
      tblDst_q   <= BYTE_RST;
    end else if (clkEn) begin
      if (tblStart) begin
        progAddr_q <= tblPtr;
        tblDst_q   <= tblReq.dst;
      end
      progReq_q <= tblStart || ((state_q == ST_TBL) && !progValid);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tblHigh_q    <= BYTE_RST;
      memWr_q      <= '0;
    end else if (clkEn) begin
      memWr_q.en <= tblDone;
      if (tblDone) begin
        tblHigh_q    <= progHi;
        memWr_q.addr <= tblDst_q;
        memWr_q.data <= progLo;
      end else if (resHiWr) begin
        tblHigh_q <= wrData;
      end
    end
  end

  // Register read port
  wire [7:0] rdMux = (sfrRdAddr == SFR_PC_LOW)  ? pc_q[7:0]
                   : (sfrRdAddr == SFR_TPTR_LO) ? tblPtrLo_q
                   : (sfrRdAddr == SFR_TPTR_HI) ? tblPtrHi_q
                   : (sfrRdAddr == SFR_TRES_HI) ? tblHigh_q
                   : (sfrRdAddr == SFR_STATUS)  ? status_q
                   : BYTE_RST;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sfrRdData_q <= BYTE_RST;
    end else if (clkEn) begin
      sfrRdData_q <= rdMux;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  wire [1:0] sysFlags = status_q[FLAG_WDEXP:FLAG_PWRDN];
  wire [PC_W-9:0] pcPage = pc_q[PC_W-1:8];

  sequence pcLowLoadSeq;
    clkEn && pcLowWr;
  endsequence

  sequence dummyOneSeq;
    fetchHold_q && (state_q == ST_DUMMY);
  endsequence

  sequence tblStartSeq;
    clkEn && tblStart;
  endsequence

  a_page_jump: assert property (
    pcLowLoadSeq |=> (pc_q[7:0] == $past(wrData)) && (pcPage == $past(pcPage)))
    else $error("Low byte write did not jump inside the page");

  a_dummy_cycle: assert property (
    pcLowLoadSeq |=> dummyOneSeq)
    else $error("Low byte write did not insert a dummy cycle");

  a_dummy_no_inc: assert property (
    (clkEn && state_q == ST_DUMMY && !pcLowWr && !pcLoad.en) |=> pc_q == $past(pc_q))
    else $error("Program counter advanced during the dummy cycle");

  a_tbl_ptr_addr: assert property (
    tblStartSeq |=> progReq_q && (progAddr_q == $past(tblPtr)))
    else $error("Table read address does not match the pointers");

  a_tbl_byte_split: assert property (
    (clkEn && tblDone) |=> memWr_q.en && (tblHigh_q == $past(progHi))
                          && (memWr_q.data == $past(progLo)) && (memWr_q.addr == $past(tblDst_q)))
    else $error("Table read bytes were not delivered");

  a_sys_flags_ro: assert property (
    (clkEn && statusWr && !watchdogExpire && !watchdogClear && !halt) |=> sysFlags == $past(sysFlags))
    else $error("Flag write changed timeout or power-down");

  a_add_carry: assert property (
    (clkEn && aluReq.valid && aluReq.op == ALU_ADD && !statusWr)
      |=> status_q[FLAG_C] == $past(addCheck[8]))
    else $error("Carry flag wrong after add");

  a_nibble_add: assert property (
    (clkEn && aluReq.valid && aluReq.op == ALU_ADD && !statusWr)
      |=> status_q[FLAG_NIB] == $past(addLowChk[4]))
    else $error("Nibble carry wrong after add");

  a_ovfl_add: assert property (
    (clkEn && aluReq.valid && aluReq.op == ALU_ADD && !statusWr)
      |=> status_q[FLAG_OVFL] == $past(addOvChk))
    else $error("Overflow flag wrong after add");

  a_zero_result: assert property (
    (clkEn && (opArith || opLogic) && !statusWr) |=> status_q[FLAG_Z] == (aluResult_q == 8'h00))
    else $error("Zero flag disagrees with result");

  a_sign_xor_flag: assert property (
    (clkEn && opArith && !statusWr) |=> status_q[FLAG_SGNX] == (status_q[FLAG_OVFL] ^ aluResult_q[7]))
    else $error("Sign-xor flag disagrees with overflow and result");

  a_chain_zero_sub: assert property (
    (clkEn && opSub && !statusWr) |=> status_q[FLAG_CHZ] == status_q[FLAG_Z])
    else $error("Chained zero differs from zero after subtract");

  a_chain_zero_sbc: assert property (
    (clkEn && opSbc && !statusWr)
      |=> status_q[FLAG_CHZ] == ($past(status_q[FLAG_CHZ]) && status_q[FLAG_Z]))
    else $error("Chained zero wrong after subtract with borrow");

  a_pwrdn_on_halt: assert property (
    (clkEn && halt) |=> status_q[FLAG_PWRDN] && (!status_q[FLAG_WDEXP] || $past(watchdogExpire)))
    else $error("Halt did not set power-down");

  a_expiry_sets_flag: assert property (
    (clkEn && watchdogExpire) |=> status_q[FLAG_WDEXP])
    else $error("Watchdog expiry did not set timeout flag");

endmodule

// *** logic/csfp_pkg.sv ***
// Shared constants and types for the status-flag, program-counter-low and table-read block
package csfp_pkg;

  localparam logic [7:0] SFR_PC_LOW  = 8'h06;
  localparam logic [7:0] SFR_TPTR_LO = 8'h07;
  localparam logic [7:0] SFR_TRES_HI = 8'h08;
  localparam logic [7:0] SFR_TPTR_HI = 8'h09;
  localparam logic [7:0] SFR_STATUS  = 8'h0A;

  localparam int FLAG_C     = 0;
  localparam int FLAG_NIB   = 1;
  localparam int FLAG_Z     = 2;
  localparam int FLAG_OVFL  = 3;
  localparam int FLAG_PWRDN = 4;
  localparam int FLAG_WDEXP = 5;
  localparam int FLAG_CHZ   = 6;
  localparam int FLAG_SGNX  = 7;

  localparam logic [7:0] STATUS_RST     = 8'h00;
  localparam logic [7:0] STATUS_SW_MASK = 8'hCF;
  localparam logic [7:0] BYTE_RST       = 8'h00;

  localparam int PC_W   = 12;
  localparam int PROG_W = 16;
  localparam logic [PC_W-1:0] PC_RST = 12'h000;

  typedef enum logic [3:0] {
    ALU_NONE, ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC,
    ALU_AND, ALU_OR, ALU_XOR, ALU_RRC, ALU_RLC
  } csfp_alu_op_t;

  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_DUMMY = 3'h2,
    ST_TBL   = 3'h4
  } csfp_state_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } csfp_byte_wr_t;

  typedef struct packed {
    logic         valid;
    csfp_alu_op_t op;
    logic [7:0]   a;
    logic [7:0]   b;
  } csfp_alu_req_t;

  typedef struct packed {
    logic            en;
    logic [PC_W-1:0] target;
  } csfp_pc_load_t;

  typedef struct packed {
    logic       en;
    logic [7:0] dst;
  } csfp_tbl_req_t;

endpackage

// *** sim/csfp_core_tb.sv ***
// Self-checking bench for the status flags, program-counter low byte and table reads
`timescale 1ns/100ps
module csfp_core_tb;
  import csfp_pkg::*;
  typedef struct packed {
    logic [7:0]   pre;
    csfp_alu_op_t op;
    logic [7:0]   a;
    logic [7:0]   b;
    logic [7:0]   res;
    logic [7:0]   st;
  } csfp_row_t;
  localparam csfp_row_t rows [18] = '{
    '{8'h00, ALU_ADD, 8'hFF, 8'h01, 8'h00, 8'h07}, '{8'h00, ALU_ADD, 8'h7F, 8'h01, 8'h80, 8'h0A},
    '{8'h00, ALU_ADD, 8'h40, 8'h40, 8'h80, 8'h08}, '{8'h00, ALU_SUB, 8'h05, 8'h03, 8'h02, 8'h03},
    '{8'h00, ALU_SUB, 8'h03, 8'h05, 8'hFE, 8'h80}, '{8'h00, ALU_SUB, 8'h33, 8'h33, 8'h00, 8'h47},
    '{8'h00, ALU_SUB, 8'h80, 8'h01, 8'h7F, 8'h89}, '{8'h41, ALU_SBC, 8'h10, 8'h10, 8'h00, 8'h47},
    '{8'h40, ALU_SBC, 8'h10, 8'h10, 8'hFF, 8'h80}, '{8'h01, ALU_SBC, 8'h10, 8'h10, 8'h00, 8'h07},
    '{8'h01, ALU_ADC, 8'h0F, 8'h00, 8'h10, 8'h02}, '{8'h40, ALU_ADD, 8'h01, 8'h01, 8'h02, 8'h40},
    '{8'hCB, ALU_AND, 8'hF0, 8'h0F, 8'h00, 8'hCF}, '{8'h04, ALU_OR, 8'h00, 8'h01, 8'h01, 8'h00},
    '{8'h0B, ALU_XOR, 8'hA5, 8'h0F, 8'hAA, 8'h0B}, '{8'h00, ALU_RRC, 8'h81, 8'h81, 8'h40, 8'h01},
    '{8'h01, ALU_RLC, 8'h40, 8'h40, 8'h81, 8'h00}, '{8'hCB, ALU_NONE, 8'h00, 8'h00, 8'h81, 8'hCB}};

  logic            mclk = 1'b0;
  logic            reset = 1'b1;
  logic            clkEn = 1'b1;
  csfp_byte_wr_t   sfrWr = '0;
  logic [7:0]      sfrRdAddr = 8'h00;
  csfp_alu_req_t   aluReq = '0;
  logic            pcInc = 1'b0;
  csfp_pc_load_t   pcLoad = '0;
  csfp_tbl_req_t   tblReq = '0;
  logic            watchdogExpire = 1'b0;
  logic            watchdogClear = 1'b0;
  logic            halt = 1'b0;
  logic [3:0]      waitCycles = 4'h0;
  logic [7:0]      sfrRdData, aluResult, status;
  logic [PC_W-1:0] pc;
  logic            fetchHold, progReq, progValid, tblBusy;
  logic [15:0]     progAddr, progData;
  csfp_byte_wr_t   memWr;
  int              errors = 0, compares = 0, cycles = 0, memWrCount = 0;

  csfp_core uut (.mclk(mclk), .reset(reset), .clkEn(clkEn), .sfrWr(sfrWr), .sfrRdAddr(sfrRdAddr),
    .sfrRdData_q(sfrRdData), .aluReq(aluReq), .aluResult_q(aluResult), .pcInc(pcInc), .pcLoad(pcLoad),
    .pc_q(pc), .fetchHold_q(fetchHold), .tblReq(tblReq), .progAddr_q(progAddr), .progReq_q(progReq),
    .progData(progData), .progValid(progValid), .tblBusy_q(tblBusy), .memWr_q(memWr),
    .watchdogExpire(watchdogExpire), .watchdogClear(watchdogClear), .halt(halt), .status_q(status));
  csfp_prog_mem progMem (.mclk(mclk), .reset(reset), .progReq(progReq), .progAddr(progAddr),
    .waitCycles(waitCycles), .progData_q(progData), .progValid_q(progValid));

  always #12.5 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (memWr.en === 1'b1) memWrCount++;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrSfr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    sfrWr <= '{1'b1, addr, data};
    @(posedge mclk);
    sfrWr <= '0;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge mclk);
    sfrRdAddr <= addr;
    @(posedge mclk);
    #1 chk(sfrRdData, exp);
  endtask

  task automatic aluOp(input csfp_alu_op_t op, input logic [7:0] a, input logic [7:0] b);
    @(posedge mclk);
    aluReq <= '{1'b1, op, a, b};
    @(posedge mclk);
    aluReq <= '0;
  endtask

  task automatic pulse(input logic w, input logic c, input logic h);
    @(posedge mclk);
    watchdogExpire <= w;
    watchdogClear <= c;
    halt <= h;
    @(posedge mclk);
    watchdogExpire <= 1'b0;
    watchdogClear <= 1'b0;
    halt <= 1'b0;
  endtask

  // Second request while busy must be dropped
  task automatic tblRead(input logic [7:0] dst, input logic [15:0] addr, input logic dup);
    @(posedge mclk);
    tblReq <= '{1'b1, dst};
    @(posedge mclk);
    tblReq <= '0;
    #1 chk({tblBusy, progReq, progAddr}, {2'b11, addr});
    if (dup) begin
      @(posedge mclk);
      tblReq <= '{1'b1, ~dst};
      @(posedge mclk);
      tblReq <= '0;
    end
    for (int i = 0; i < 20 && memWr.en !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({tblBusy, memWr.en, memWr.addr, memWr.data}, {2'b01, dst, addr[7:0] ^ 8'hC3});
    rd(SFR_TRES_HI, addr[15:8] ^ 8'h5A);
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    #1 chk({status, pc}, 20'h0_0000);
    chk({fetchHold, tblBusy, progReq, memWr.en}, 4'h0);
    foreach (rows[i]) begin
      wrSfr(SFR_STATUS, rows[i].pre);
      aluOp(rows[i].op, rows[i].a, rows[i].b);
      #1 chk({aluResult, status}, {rows[i].res, rows[i].st});
    end
    wrSfr(SFR_STATUS, 8'hFF);
    #1 chk(status, 8'hCF);
    pulse(1'b1, 1'b0, 1'b0);
    #1 chk(status, 8'hEF);
    wrSfr(SFR_STATUS, 8'h00);
    rd(SFR_STATUS, 8'h20);
    rd(8'h0B, 8'h00);
    pulse(1'b0, 1'b0, 1'b1);
    #1 chk(status, 8'h10);
    wrSfr(SFR_STATUS, 8'hFF);
    #1 chk(status, 8'hDF);
    pulse(1'b0, 1'b1, 1'b0);
    #1 chk(status, 8'hCF);
    pulse(1'b1, 1'b0, 1'b1);
    #1 chk(status, 8'hFF);
    pulse(1'b0, 1'b1, 1'b0);
    @(posedge mclk);
    clkEn <= 1'b0;
    aluReq <= '{1'b1, ALU_ADD, 8'hFF, 8'h01};
    @(posedge mclk);
    clkEn <= 1'b1;
    aluReq <= '0;
    #1 chk({aluResult, status}, 16'h81CF);
    @(posedge mclk);
    sfrWr <= '{1'b1, SFR_STATUS, 8'h41};
    aluReq <= '{1'b1, ALU_ADD, 8'hFF, 8'h01};
    @(posedge mclk);
    sfrWr <= '0;
    aluReq <= '0;
    #1 chk(status, 8'h41);
    @(posedge mclk);
    pcLoad <= '{1'b1, 12'h3A0};
    @(posedge mclk);
    pcLoad <= '0;
    sfrWr <= '{1'b1, SFR_PC_LOW, 8'h55};
    pcInc <= 1'b1;
    @(posedge mclk);
    sfrWr <= '0;
    #1 chk({pc, fetchHold}, {12'h355, 1'b1});
    @(posedge mclk);
    #1 chk({pc, fetchHold}, {12'h355, 1'b0});
    @(posedge mclk);
    pcInc <= 1'b0;
    #1 chk(pc, 12'h356);
    rd(SFR_PC_LOW, 8'h56);
    wrSfr(SFR_TPTR_LO, 8'h34);
    wrSfr(SFR_TPTR_HI, 8'h12);
    rd(SFR_TPTR_LO, 8'h34);
    rd(SFR_TPTR_HI, 8'h12);
    tblRead(8'h20, 16'h1234, 1'b0);
    wrSfr(SFR_TPTR_LO, 8'h35);
    waitCycles <= 4'h3;
    tblRead(8'h21, 16'h1235, 1'b1);
    repeat (8) @(posedge mclk);
    #1 chk(24'(memWrCount), 24'h00_0002);
    // Reset again in mid-run: every flag and the table result must clear
    @(posedge mclk);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    #1 chk({status, pc, fetchHold, tblBusy, memWr.en}, 23'h00_0000);
    rd(SFR_TRES_HI, 8'h00);
    end_sim();
  end
endmodule

// *** sim/csfp_prog_mem.sv ***
// Program memory model that answers table-read word requests
`timescale 1ns/100ps
module csfp_prog_mem (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // Request from the core and answer pacing
  input  wire logic        progReq,
  input  wire logic [15:0] progAddr,
  input  wire logic [3:0]  waitCycles,
  // Returned word
  output logic [15:0]      progData_q,
  output logic             progValid_q
);
  logic [3:0] waitCnt_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      waitCnt_q   <= 4'h0;
      progValid_q <= 1'b0;
      progData_q  <= 16'h0000;
    end else if (progReq && !progValid_q && waitCnt_q == waitCycles) begin
      waitCnt_q   <= 4'h0;
      progValid_q <= 1'b1;
      progData_q  <= {progAddr[15:8] ^ 8'h5A, progAddr[7:0] ^ 8'hC3};
    end else begin
      waitCnt_q   <= (progReq && !progValid_q) ? waitCnt_q + 4'h1 : 4'h0;
      progValid_q <= 1'b0;
      // After its answer cycle the word is inverted on every clock
      progData_q  <= ~progData_q;
    end
  end
endmodule
